// >>> pkg/dhp_pkg.sv
// dhp_pkg: constants and types shared by the high-speed lane receiver files.
// Assumes nothing of its surroundings; it holds definitions only.
`default_nettype none
package dhp_pkg;

   // Low-power line levels as {dp, dn}
   localparam logic [1:0] DHP_LP11 = 2'h3;
   localparam logic [1:0] DHP_LP01 = 2'h1;
   localparam logic [1:0] DHP_LP00 = 2'h0;

   // Sync pattern as the six newest bits of the shift register
   localparam logic [5:0] DHP_SYNC_PAT = 6'h1D;
   // Bit index reached when the pattern is found; two sync bits remain
   localparam logic [2:0] DHP_SYNC_TAIL = 3'h6;
   // Last bit index of a byte
   localparam logic [2:0] DHP_BIT_LAST = 3'h7;
   // Header byte index that carries the check byte
   localparam logic [1:0] DHP_HDR_LAST = 2'h3;

   // Data types that the receiver treats specially
   localparam logic [5:0] DHP_DT_EOTP = 6'h08;
   localparam logic [5:0] DHP_DT_MAXRET = 6'h37;
   // Low type nibbles that select the long format
   localparam logic [3:0] DHP_LONG_NIB_A = 4'h9;
   localparam logic [3:0] DHP_LONG_NIB_B = 4'hC;
   localparam logic [3:0] DHP_LONG_NIB_C = 4'hE;

   // Footer values with fixed meaning
   localparam logic [15:0] DHP_CRC_EMPTY = 16'hFFFF;
   localparam logic [15:0] DHP_CRC_NONE = 16'h0000;
   localparam logic [15:0] DHP_WC_ZERO = 16'h0000;
   localparam logic [15:0] DHP_WC_ONE = 16'h0001;
   // Return size limit before the host sets one
   localparam logic [15:0] DHP_MAXRET_RST = 16'h0001;
   localparam logic [7:0] DHP_ECC_OK = 8'h00;

   // Syndrome of a single flipped header bit, D0 first; also the parity masks
   localparam logic [7:0] DHP_SYN_TAB [24] = '{
      8'h07, 8'h0B, 8'h0D, 8'h0E, 8'h13, 8'h15, 8'h16, 8'h19,
      8'h1A, 8'h1C, 8'h23, 8'h25, 8'h26, 8'h29, 8'h2A, 8'h2C,
      8'h31, 8'h32, 8'h34, 8'h38, 8'h1F, 8'h2F, 8'h37, 8'h3B};

   // Receiver states, Gray coded along the path IDLE, REQ, SYNC, HDR, PAY, FOOT
   typedef enum logic [2:0] {
      DHP_ST_IDLE = 3'h0,
      DHP_ST_REQ = 3'h1,
      DHP_ST_SYNC = 3'h3,
      DHP_ST_HDR = 3'h2,
      DHP_ST_PAY = 3'h6,
      DHP_ST_FOOT = 3'h7,
      DHP_ST_DRAIN = 3'h5
   } dhp_state_t;

endpackage
`default_nettype wire

// >>> pkg/dhp_ecc_if.sv
// dhp_ecc_if: carries a packet header to the check-byte decoder and back.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ns
`default_nettype none
interface dhp_ecc_if;
   logic [23:0] data;  // Identifier and two following bytes
   logic [7:0] ecc;    // Received check byte
   logic [23:0] fixed; // Header after single-bit repair
   logic single;       // One bit was wrong and is repaired
   logic multi;        // Damage beyond repair
   modport chk (input data, input ecc, output fixed, output single, output multi);
   modport user (output data, output ecc, input fixed, input single, input multi);
endinterface
`default_nettype wire

// >>> hw/dhp_ecc_check.sv
// dhp_ecc_check: header check-byte decoder, repairs one bit, flags more.
// Assumes the caller holds data and ecc stable; no clock, pure logic.
`timescale 1ns/1ns
`default_nettype none
module dhp_ecc_check
   import dhp_pkg::*;
(
   dhp_ecc_if.chk e
);

   logic [7:0] calc;  // Check byte recomputed from the header
   logic [7:0] syn;   // Received versus computed
   logic [23:0] hit;  // Syndrome names this data bit

   // Recompute parity: each set data bit folds in its table column
   always_comb begin
      calc = DHP_ECC_OK;
      for (int i = 0; i < 24; i++) begin
         if (e.data[i]) begin
            calc = calc ^ DHP_SYN_TAB[i];
         end
      end
   end

   assign syn = calc ^ e.ecc;

   // One comparator per data bit against its single-error syndrome
   for (genvar i = 0; i < 24; i++) begin : g_hit
      assign hit[i] = (syn == DHP_SYN_TAB[i]);
   end

   assign e.fixed = e.data ^ hit;
   // A one-hot syndrome means the check byte itself took the hit
   assign e.single = (syn != DHP_ECC_OK) && ((|hit) || $onehot(syn));
   assign e.multi = (syn != DHP_ECC_OK) && !(|hit) && !$onehot(syn);

endmodule // dhp_ecc_check
`default_nettype wire

// >>> hw/dhp_hs_rx.sv
// dhp_hs_rx: high-speed receive path of the display link data lane.
// Lane levels, the HS bit and the lane clock are asynchronous pins;
// eotp_en comes from core_clk logic. Bits are taken on both lane clock edges.
`timescale 1ns/1ns
`default_nettype none
module dhp_hs_rx
   import dhp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic lane_dp,
   input wire logic lane_dn,
   input wire logic lane_hs,
   input wire logic rx_clock_lane,
   input wire logic eotp_en,
   output logic term_en,
   output logic hs_data_transfer,
   output logic hdr_valid,
   output logic [1:0] hdr_vc,
   output logic [5:0] hdr_dt,
   output logic [15:0] hdr_wc,
   output logic hdr_long,
   output logic pay_valid,
   output logic [7:0] pay_data,
   output logic pkt_end,
   output logic [15:0] pkt_crc,
   output logic crc_absent,
   output logic crc_empty_bad,
   output logic ecc_fixed,
   output logic ecc_fail,
   output logic frame_err,
   output logic eotp_seen,
   output logic [15:0] max_ret_size
);

   // Synchroniser stages; the first of each pair feeds only the second
   logic [1:0] lp_m_q, lp_s_q;
   logic hs_m_q, hs_s_q;
   logic ck_m_q, ck_s_q, ck_d_q;

   // Control state
   dhp_state_t state_q, state_d;
   logic term_en_q;      // Lane termination
   logic locked_q;       // Sync pattern found in this burst
   logic [2:0] bit_cnt_q; // Bit index within the byte
   logic [7:0] sr_q;     // Bit shift register, newest bit on top
   logic [1:0] idx_q;    // Byte index in header or footer
   logic [23:0] hbuf_q;  // First three header bytes
   logic [15:0] cnt_q;   // Payload bytes still to come
   logic [7:0] crc_lo_q; // Footer low byte

   // Output registers
   logic hdr_valid_q, hdr_long_q, pay_valid_q, pkt_end_q;
   logic [1:0] hdr_vc_q;
   logic [5:0] hdr_dt_q;
   logic [15:0] hdr_wc_q, pkt_crc_q, max_ret_q;
   logic [7:0] pay_data_q;
   logic crc_absent_q, crc_empty_bad_q, ecc_fixed_q, ecc_fail_q;
   logic frame_err_q, eotp_seen_q, hs_q;

   // Decoded lane conditions
   logic lp11, lp01, lp00, ck_edge;
   // Bit and byte strobes
   logic in_hs, in_pkt, bit_ev, sync_hit, byte_done;
   logic [7:0] sr_d;
   // Packet decode
   logic hdr_done, foot_done, pay_last, accept, is_eotp, term_d;
   logic fix_long;
   logic [5:0] fix_dt;
   logic [1:0] fix_vc;
   logic [15:0] fix_wc, crc_full;
   logic lp_end;

   // Header decoder shares its signals through the carrier
   dhp_ecc_if ecc_if ();

   dhp_ecc_check u_ecc (
      .e (ecc_if.chk)
   );

   // Resynchronise the pins; lane clock gets a third stage for edges
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lp_m_q <= DHP_LP11;
         lp_s_q <= DHP_LP11;
         hs_m_q <= 1'b0;
         hs_s_q <= 1'b0;
         ck_m_q <= 1'b0;
         ck_s_q <= 1'b0;
         ck_d_q <= 1'b0;
      end else begin
         lp_m_q <= {lane_dp, lane_dn};
         lp_s_q <= lp_m_q;
         hs_m_q <= lane_hs;
         hs_s_q <= hs_m_q;
         ck_m_q <= rx_clock_lane;
         ck_s_q <= ck_m_q;
         ck_d_q <= ck_s_q;
      end
   end

   // Line level decode
   assign lp11 = (lp_s_q == DHP_LP11);
   assign lp01 = (lp_s_q == DHP_LP01);
   assign lp00 = (lp_s_q == DHP_LP00);
   // Double data rate: either lane clock edge carries a bit
   assign ck_edge = ck_s_q ^ ck_d_q;

   // Bit strobes only count while the lane is in high-speed mode
   assign in_hs = (state_q == DHP_ST_SYNC) || (state_q == DHP_ST_HDR) ||
                  (state_q == DHP_ST_PAY) || (state_q == DHP_ST_FOOT);
   assign bit_ev = ck_edge && in_hs;
   assign sr_d = {hs_s_q, sr_q[7:1]};
   assign sync_hit = (state_q == DHP_ST_SYNC) && !locked_q &&
                     (sr_q[7:2] == DHP_SYNC_PAT);
   assign byte_done = bit_ev && locked_q && (bit_cnt_q == DHP_BIT_LAST);

   // Header check: data bytes plus the check byte just completed
   assign ecc_if.data = hbuf_q;
   assign ecc_if.ecc = sr_d;
   assign fix_vc = ecc_if.fixed[7:6];
   assign fix_dt = ecc_if.fixed[5:0];
   assign fix_wc = ecc_if.fixed[23:8];
   assign fix_long = (fix_dt[3:0] == DHP_LONG_NIB_A) ||
                     (fix_dt[3:0] == DHP_LONG_NIB_B) ||
                     (fix_dt[3:0] == DHP_LONG_NIB_C);
   assign is_eotp = eotp_en && !fix_long && (fix_dt == DHP_DT_EOTP);

   assign hdr_done = byte_done && (state_q == DHP_ST_HDR) && (idx_q == DHP_HDR_LAST);
   assign accept = hdr_done && !ecc_if.multi && !is_eotp;
   assign foot_done = byte_done && (state_q == DHP_ST_FOOT) && idx_q[0];
   assign pay_last = (cnt_q == DHP_WC_ONE);
   assign crc_full = {sr_d, crc_lo_q};

   // A packet is open from its first header byte to its last footer byte
   assign in_pkt = ((state_q == DHP_ST_HDR) && (idx_q != 2'h0)) ||
                   (state_q == DHP_ST_PAY) || (state_q == DHP_ST_FOOT);
   assign lp_end = lp11 && (state_q != DHP_ST_IDLE);
   assign term_d = (state_d != DHP_ST_IDLE) && (state_d != DHP_ST_REQ);

   // Lane and packet sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         DHP_ST_IDLE: begin
            if (lp01) begin
               state_d = DHP_ST_REQ;
            end
         end
         DHP_ST_REQ: begin
            if (lp00) begin
               state_d = DHP_ST_SYNC;
            end else if (!lp01) begin
               state_d = DHP_ST_IDLE;  // Not a high-speed entry after all
            end
         end
         // Sync byte ends at its eighth bit
         DHP_ST_SYNC: begin
            if (byte_done) begin
               state_d = DHP_ST_HDR;
            end
         end
         DHP_ST_HDR: begin
            if (hdr_done) begin
               if (ecc_if.multi || is_eotp) begin
                  state_d = DHP_ST_DRAIN;  // Count untrusted or burst over
               end else if (fix_long) begin
                  state_d = (fix_wc == DHP_WC_ZERO) ? DHP_ST_FOOT : DHP_ST_PAY;
               end
            end
         end
         DHP_ST_PAY: begin
            if (byte_done && pay_last) begin
               state_d = DHP_ST_FOOT;
            end
         end
         DHP_ST_FOOT: begin
            if (foot_done) begin
               state_d = DHP_ST_HDR;
            end
         end
         // Ignore the rest of the burst until the stop state
         DHP_ST_DRAIN: begin
            state_d = DHP_ST_DRAIN;
         end
         default: begin
            state_d = DHP_ST_IDLE;
         end
      endcase
      if (lp_end) begin
         state_d = DHP_ST_IDLE;
      end
   end

   // State, termination and activity flag
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= DHP_ST_IDLE;
         term_en_q <= 1'b0;
         hs_q <= 1'b0;
      end else begin
         state_q <= state_d;
         term_en_q <= term_d;
         hs_q <= (state_d != DHP_ST_IDLE) && (state_d != DHP_ST_REQ);
      end
   end

   // Bit shifter, cleared outside high speed so stale bits never fake a sync
   always_ff @(posedge core_clk) begin
      if (srst || !in_hs) begin
         sr_q <= 8'h00;
      end else if (bit_ev) begin
         sr_q <= sr_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || !in_hs) begin
         locked_q <= 1'b0;
         bit_cnt_q <= 3'h0;
      end else if (sync_hit) begin
         locked_q <= 1'b1;
         bit_cnt_q <= DHP_SYNC_TAIL;
      end else if (bit_ev && locked_q) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || (state_q == DHP_ST_SYNC)) begin
         idx_q <= 2'h0;
      end else if (byte_done && ((state_q == DHP_ST_HDR) || (state_q == DHP_ST_FOOT))) begin
         idx_q <= (hdr_done || foot_done) ? 2'h0 : idx_q + 2'h1;
      end
   end

   // Header bytes land at their index; the check byte is used live
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hbuf_q <= 24'h000000;
      end else if (byte_done && (state_q == DHP_ST_HDR) && !hdr_done) begin
         hbuf_q[{idx_q, 3'h0} +: 8] <= sr_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_q <= DHP_WC_ZERO;
      end else if (hdr_done) begin
         cnt_q <= fix_wc;
      end else if (byte_done && (state_q == DHP_ST_PAY)) begin
         cnt_q <= cnt_q - DHP_WC_ONE;
      end
   end

   // Footer low byte
   always_ff @(posedge core_clk) begin
      if (srst) begin
         crc_lo_q <= 8'h00;
      end else if (byte_done && (state_q == DHP_ST_FOOT) && !idx_q[0]) begin
         crc_lo_q <= sr_d;
      end
   end

   // Event pulses, one cycle each
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hdr_valid_q <= 1'b0;
         pay_valid_q <= 1'b0;
         pkt_end_q <= 1'b0;
         ecc_fixed_q <= 1'b0;
         ecc_fail_q <= 1'b0;
         frame_err_q <= 1'b0;
         eotp_seen_q <= 1'b0;
      end else begin
         hdr_valid_q <= accept;
         pay_valid_q <= byte_done && (state_q == DHP_ST_PAY);
         pkt_end_q <= (accept && !fix_long) || foot_done;
         ecc_fixed_q <= hdr_done && ecc_if.single;
         ecc_fail_q <= hdr_done && ecc_if.multi;
         frame_err_q <= lp_end && in_pkt && !foot_done && !(accept && !fix_long);
         eotp_seen_q <= hdr_done && !ecc_if.multi && is_eotp;
      end
   end

   // Header fields hold until the next accepted header
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hdr_vc_q <= 2'h0;
         hdr_dt_q <= 6'h00;
         hdr_wc_q <= DHP_WC_ZERO;
         hdr_long_q <= 1'b0;
      end else if (accept) begin
         hdr_vc_q <= fix_vc;
         hdr_dt_q <= fix_dt;
         hdr_wc_q <= fix_wc;
         hdr_long_q <= fix_long;
      end
   end

   // Payload byte, valid with pay_valid only
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pay_data_q <= 8'h00;
      end else if (byte_done && (state_q == DHP_ST_PAY)) begin
         pay_data_q <= sr_d;
      end
   end

   // Footer results; the checksum itself is not recomputed here
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pkt_crc_q <= DHP_CRC_NONE;
         crc_absent_q <= 1'b0;
         crc_empty_bad_q <= 1'b0;
      end else begin
         if (foot_done) begin
            pkt_crc_q <= crc_full;
         end
         crc_absent_q <= foot_done && (crc_full == DHP_CRC_NONE);
         crc_empty_bad_q <= foot_done && (hdr_wc_q == DHP_WC_ZERO) &&
                            (crc_full != DHP_CRC_EMPTY) && (crc_full != DHP_CRC_NONE);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         max_ret_q <= DHP_MAXRET_RST;
      end else if (accept && !fix_long && (fix_dt == DHP_DT_MAXRET)) begin
         max_ret_q <= fix_wc;
      end
   end

   // Ports come straight from the registers
   assign term_en = term_en_q;
   assign hs_data_transfer = hs_q;
   assign hdr_valid = hdr_valid_q;
   assign hdr_vc = hdr_vc_q;
   assign hdr_dt = hdr_dt_q;
   assign hdr_wc = hdr_wc_q;
   assign hdr_long = hdr_long_q;
   assign pay_valid = pay_valid_q;
   assign pay_data = pay_data_q;
   assign pkt_end = pkt_end_q;
   assign pkt_crc = pkt_crc_q;
   assign crc_absent = crc_absent_q;
   assign crc_empty_bad = crc_empty_bad_q;
   assign ecc_fixed = ecc_fixed_q;
   assign ecc_fail = ecc_fail_q;
   assign frame_err = frame_err_q;
   assign eotp_seen = eotp_seen_q;
   assign max_ret_size = max_ret_q;

   // Payload bytes seen in the current packet, read by the checks only
   logic [15:0] pay_seen_q;
   always_ff @(posedge core_clk) begin
      if (srst || hdr_valid_q) begin
         pay_seen_q <= DHP_WC_ZERO;
      end else if (pay_valid_q) begin
         pay_seen_q <= pay_seen_q + DHP_WC_ONE;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_settle;
      (state_q == DHP_ST_REQ) && lp00;
   endsequence

   sequence s_long_done;
      pkt_end_q && hdr_long_q;
   endsequence

   term_on_a: assert property (s_settle |=> term_en_q && (state_q == DHP_ST_SYNC))
      else $error("termination not on after settle");
   term_off_a: assert property (lp_end |=> !term_en_q ##1 !term_en_q || !lp11)
      else $error("termination still on in stop state");
   sync_lock_a: assert property ($rose(locked_q) |-> $past(sync_hit))
      else $error("lock without sync pattern");
   pay_count_a: assert property (s_long_done |-> pay_seen_q == hdr_wc_q)
      else $error("payload length differs from word count");
   short_end_a: assert property (hdr_valid_q && !hdr_long_q |-> pkt_end_q)
      else $error("short packet did not end at its header");
   eotp_gate_a: assert property (eotp_seen_q |-> $past(eotp_en) && !hdr_valid_q &&
                                 (state_q inside {DHP_ST_DRAIN, DHP_ST_IDLE}))
      else $error("end packet taken while disabled");
   ecc_fail_a: assert property (ecc_fail_q |-> !hdr_valid_q &&
                                (state_q inside {DHP_ST_DRAIN, DHP_ST_IDLE}))
      else $error("bad header was passed on");
   next_hdr_a: assert property (pkt_end_q |-> state_q inside {DHP_ST_HDR, DHP_ST_IDLE})
      else $error("no header expected after packet end");
   frame_err_a: assert property (frame_err_q |-> (state_q == DHP_ST_IDLE) && !pkt_end_q)
      else $error("framing error without dropping packet");
   crc_empty_a: assert property (crc_empty_bad_q |-> (hdr_wc_q == DHP_WC_ZERO) &&
                                 (pkt_crc_q != DHP_CRC_EMPTY))
      else $error("empty checksum flag wrong");
   max_ret_a: assert property ($changed(max_ret_q) |-> hdr_valid_q &&
                               (hdr_dt_q == DHP_DT_MAXRET) && (max_ret_q == hdr_wc_q))
      else $error("return limit changed without command");

endmodule // dhp_hs_rx
`default_nettype wire

// >>> testbench/dhp_host_model.sv
// dhp_host_model: host transmitter that drives the data lane and its lane clock.
// Assumes a 160 ns lane clock whose two edges each carry one bit.
`timescale 1ns/1ns
`default_nettype none
module dhp_host_model (
   output logic lane_dp,
   output logic lane_dn,
   output logic lane_hs,
   output logic rx_clock_lane
);
   // Stop state at start, lane clock still
   initial begin
      lane_dp = 1'b1;
      lane_dn = 1'b1;
      lane_hs = 1'b1;
      rx_clock_lane = 1'b0;
   end
   // lane clock toggles only while bits go out
   task automatic put_bit(input logic b);
      lane_hs = b;
      #40 rx_clock_lane = ~rx_clock_lane;
      #40;
   endtask
   task automatic put_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) put_bit(v[i]);
   endtask
   // request, settle at HS-0, then sync byte
   task automatic start_burst();
      lane_dp = 1'b0;
      #100 lane_dn = 1'b0;
      lane_hs = 1'b0;
      #100 put_byte(8'h1D);
   endtask
   // hold inverse of last bit, then back to stop
   task automatic end_burst(input int n);
      logic t;
      t = ~lane_hs;
      for (int i = 0; i < n; i++) put_bit(t);
      lane_dp = 1'b1;
      lane_dn = 1'b1;
      #200;
   endtask
endmodule // dhp_host_model
`default_nettype wire

// >>> testbench/testbench.sv
// testbench: sends bursts through the host model into dhp_hs_rx and checks outputs.
// Assumes a 100 MHz core clock; the host model makes the lane timing.
`timescale 1ns/1ns
`default_nettype none
module testbench
   import dhp_pkg::*;
;
   // One packet per row: identifier, word count, footer, header damage mask
   typedef struct packed {
      logic [7:0] di;
      logic [15:0] wc;
      logic [15:0] ft;
      logic [31:0] msk;
   } dhp_row_t;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic eotp_en = 1'b0;
   logic lane_dp, lane_dn, lane_hs, rx_clock_lane, term_en, hs_data_transfer, hdr_valid;
   logic hdr_long, pay_valid, pkt_end, crc_absent, crc_empty_bad, ecc_fixed, ecc_fail;
   logic frame_err, eotp_seen;
   logic [1:0] hdr_vc;
   logic [5:0] hdr_dt;
   logic [15:0] hdr_wc, pkt_crc, max_ret_size;
   logic [7:0] pay_data;
   logic [25:0] hq[$]; // Headers with repair flag
   logic [17:0] eq[$]; // Packet ends with footer flags
   logic [7:0] pq[$];  // Payload bytes
   int n_fail, n_ferr, n_eotp, cycles, num_errors, total_checks;
   // Ordinary cases, sent back to back in one burst
   dhp_row_t rows [8] = '{'{8'h05, 16'h0010, 16'h0000, 32'h0}, '{8'h29, 16'h0001, 16'h1234, 32'h0},
      '{8'h39, 16'h0000, 16'hFFFF, 32'h0}, '{8'h79, 16'h0000, 16'h0000, 32'h0},
      '{8'hB9, 16'h0000, 16'h1234, 32'h0}, '{8'hC5, 16'hA55A, 16'h0000, 32'h8},
      '{8'h29, 16'h0003, 16'hBEEF, 32'h0400_0000}, '{8'h37, 16'h0040, 16'h0000, 32'h0}};

   dhp_host_model host (.lane_dp, .lane_dn, .lane_hs, .rx_clock_lane);
   dhp_hs_rx uut (.core_clk, .srst, .lane_dp, .lane_dn, .lane_hs, .rx_clock_lane, .eotp_en,
      .term_en, .hs_data_transfer, .hdr_valid, .hdr_vc, .hdr_dt, .hdr_wc, .hdr_long, .pay_valid,
      .pay_data, .pkt_end, .pkt_crc, .crc_absent, .crc_empty_bad, .ecc_fixed, .ecc_fail,
      .frame_err, .eotp_seen, .max_ret_size);

   always #5 core_clk = ~core_clk;

   // Collect pulses; the watchdog cuts a hang short
   always @(posedge core_clk) begin
      if (hdr_valid === 1'b1) hq.push_back({ecc_fixed, hdr_long, hdr_vc, hdr_dt, hdr_wc});
      if (pkt_end === 1'b1) eq.push_back({pkt_crc, crc_absent, crc_empty_bad});
      if (pay_valid === 1'b1) pq.push_back(pay_data);
      if (ecc_fail === 1'b1) n_fail++;
      if (frame_err === 1'b1) n_ferr++;
      if (eotp_seen === 1'b1) n_eotp++;
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Check byte from the single-bit syndrome columns
   function automatic logic [7:0] ecc_of(input logic [23:0] d);
      ecc_of = 8'h00;
      for (int i = 0; i < 24; i++) if (d[i]) ecc_of ^= DHP_SYN_TAB[i];
   endfunction

   function automatic logic is_long(input logic [7:0] di);
      is_long = di[3:0] inside {DHP_LONG_NIB_A, DHP_LONG_NIB_B, DHP_LONG_NIB_C};
   endfunction

   // Header with optional damage; payload cut after lim bytes drops the footer
   task automatic send_pkt(input dhp_row_t r, input int lim);
      logic [31:0] h;
      h = {ecc_of({r.wc, r.di}), r.wc, r.di} ^ r.msk;
      for (int i = 0; i < 4; i++) host.put_byte(h[8*i +: 8]);
      if (is_long(r.di)) begin
         for (int k = 0; k < r.wc && k < lim; k++) host.put_byte(8'h1D + k[7:0]);
         if (lim >= r.wc) host.put_byte(r.ft[7:0]);
         if (lim >= r.wc) host.put_byte(r.ft[15:8]);
      end
   endtask

   task automatic clr();
      hq.delete();
      eq.delete();
      pq.delete();
      n_fail = 0;
      n_ferr = 0;
      n_eotp = 0;
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      logic [15:0] crc;
      logic lg;
      dhp_row_t r;
      logic [17:0] ex;
      repeat (16) @(posedge core_clk);
      #1 srst = 1'b0;
      repeat (2) @(posedge core_clk);
      // Off the edge, so pins and checks sit clear of the core clock
      #1;
      chk({term_en, hs_data_transfer, max_ret_size, pkt_crc}, {2'b00, DHP_MAXRET_RST, 16'h0},
          "reset");
      clr();
      host.start_burst();
      chk({term_en, hs_data_transfer}, 2'b11, "lane on");
      foreach (rows[i]) send_pkt(rows[i], 1000);
      host.end_burst(4);
      chk({term_en, 4'(n_ferr)}, 5'h0, "lane off");
      crc = 16'h0;
      foreach (rows[i]) begin
         r = rows[i];
         lg = is_long(r.di);
         if (lg) crc = r.ft;
         chk(hq.pop_front(), {|r.msk, lg, r.di, r.wc}, "header");
         ex = {crc, lg && crc == DHP_CRC_NONE,
               lg && r.wc == DHP_WC_ZERO && crc != DHP_CRC_EMPTY && crc != DHP_CRC_NONE};
         chk(eq.pop_front(), ex, "packet end");
         for (int k = 0; lg && k < r.wc; k++) begin
            chk(pq.pop_front(), 8'h1D + k[7:0], "payload");
         end
      end
      // Nothing extra may have come out of the burst
      chk({4'(hq.size()), 4'(eq.size()), 4'(pq.size())}, 12'h000, "leftover");
      chk(max_ret_size, 16'h0040, "return size");
      for (int e = 1; e >= 0; e--) begin
         @(posedge core_clk);
         #1 eotp_en = e[0];
         clr();
         host.start_burst();
         send_pkt('{8'h08, 16'h0F0F, 16'h0, 32'h0}, 0);
         send_pkt('{8'h05, 16'h0011, 16'h0, 32'h0}, 0);
         host.end_burst(4);
         chk({4'(n_eotp), 4'(hq.size())}, {4'(e), 4'(2 - 2 * e)}, "end packet");
      end
      clr();
      host.start_burst();
      send_pkt('{8'h05, 16'h0010, 16'h0, 32'h3}, 0);
      send_pkt('{8'h05, 16'h0011, 16'h0, 32'h0}, 0);
      host.end_burst(4);
      chk({4'(n_fail), 4'(hq.size())}, 8'h10, "double error");
      clr();
      host.start_burst();
      send_pkt('{8'h29, 16'h0005, 16'h0, 32'h0}, 2);
      host.end_burst(0);
      chk({4'(n_ferr), 4'(eq.size()), 4'(pq.size())}, 12'h102, "early stop");
      // Reset in mid-burst: outputs go idle, and no stale frame error follows
      clr();
      host.start_burst();
      send_pkt('{8'h29, 16'h0005, 16'h0, 32'h0}, 1);
      srst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 srst = 1'b0;
      chk({term_en, hs_data_transfer, max_ret_size}, {2'b00, DHP_MAXRET_RST}, "mid reset");
      host.end_burst(0);
      chk({4'(n_ferr), 4'(hq.size())}, 8'h01, "after reset");
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
